// *** shared/dap_pkg.sv ***
/*
  Package for the dual auxiliary pulse-width timer: register offsets, field positions,
  reset values and timing constants.
  Assumes a 125 MHz core clock and a 32-bit AXI4-Lite register bus.
*/
package dap_pkg;
  localparam int unsigned DAP_ADDR_W = 6;
  localparam logic [5:0] OFF_PERIOD_0 = 6'h00;
  localparam logic [5:0] OFF_PERIOD_1 = 6'h04;
  localparam logic [5:0] OFF_ONTIME_0 = 6'h08;
  localparam logic [5:0] OFF_ONTIME_1 = 6'h0C;
  localparam logic [5:0] OFF_MODE_CTRL = 6'h10;
  localparam logic [5:0] OFF_PORT_DATA_HIGH = 6'h14;
  localparam logic [5:0] OFF_PIN_FUNC_SEL = 6'h18;
  localparam logic [5:0] OFF_STATUS = 6'h1C;
  localparam int unsigned MODE_INDEP_BIT = 8;
  localparam int unsigned PDH_FUNC_BIT = 1;
  localparam int unsigned PFS_AUX_OUT_ONE_BIT = 7;
  localparam logic [7:0] RST_PERIOD = 8'hFF;
  localparam logic [7:0] RST_ONTIME = 8'h00;
  localparam logic [8:0] RST_MODE = 9'h000;
  localparam logic [1:0] RST_PDH = 2'h2;
  localparam logic [7:0] RST_PFS = 8'hFF;
  localparam int unsigned TICK_CYCLES = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// *** src/dap_channel.sv ***
/*
  One auxiliary channel: an 8-bit step counter that wraps at its period and a
  compare against an on-time latched at each cycle start.
  Assumes a step strobe every second clock and a restart pulse from the register file or, for output 1, the offset delay.
*/
`timescale 1ns/1ns
module dap_channel (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic step,
  input wire logic restart,
  input wire logic hold,
  input wire logic [7:0] period,
  input wire logic [7:0] ontime,
  output logic wave,
  output logic wrap
);
  logic [7:0] count;
  logic [7:0] on_live;
  logic [7:0] next_count;
  logic [7:0] next_on_live;
  logic next_wave;

  always_comb begin
    next_count = count;
    next_on_live = on_live;
    if (restart) begin
      next_count = 8'h00;
      next_on_live = ontime;
    end else if (step && !hold) begin
      if (count >= period) begin
        next_count = 8'h00;
        // The on-time is only picked up at the start of a new cycle.
        next_on_live = ontime;
      end else begin
        next_count = count + 8'h01;
      end
    end
    // High while the step count is below the on-time; above period means always high.
    next_wave = (restart || !hold) && ((next_count < next_on_live) || (next_on_live > period));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 8'h00;
      on_live <= 8'h00;
      wave <= 1'b0;
    end else begin
      count <= next_count;
      on_live <= next_on_live;
      wave <= next_wave;
    end
  end

  assign wrap = step && !hold && !restart && (count >= period);
endmodule

// *** src/dap_timer.sv ***
/*
  Dual auxiliary pulse-width timer with an AXI4-Lite register slave.
  Assumes one 125 MHz clock and a synchronous active-low reset; the pins
  drive the external converter or filter circuitry.
*/
`timescale 1ns/1ns
module dap_timer (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dap_pkg::DAP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dap_pkg::DAP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic aux_out_zero,
  output logic aux_out_one,
  output logic aux_zero_is_aux,
  output logic aux_one_is_aux
);
  import dap_pkg::*;

  logic [7:0] aux_period_0;
  logic [7:0] aux_period_1;
  logic [7:0] aux_ontime_0;
  logic [7:0] aux_ontime_1;
  logic [8:0] mode_control_register;
  logic [1:0] port_data_high;
  logic [7:0] pin_function_select;
  logic [7:0] next_period_0;
  logic [7:0] next_period_1;
  logic [7:0] next_ontime_0;
  logic [7:0] next_ontime_1;
  logic [8:0] next_mode;
  logic [1:0] next_pdh;
  logic [7:0] next_pfs;

  logic aw_held;
  logic w_held;
  logic [DAP_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic next_w_held;
  logic [DAP_ADDR_W-1:0] next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic do_write;
  logic period_write;

  logic phase;
  logic next_phase;
  logic step;
  logic independent;
  logic [7:0] per_1_eff;
  logic wave_0;
  logic wave_1;
  logic wrap_0;
  logic restart_1;
  logic hold_1;
  logic first_wait;
  logic next_first_wait;
  logic [7:0] delay_cnt;
  logic delay_run;
  logic [7:0] next_delay_cnt;
  logic next_delay_run;
  logic next_out_zero;
  logic next_out_one;

  function automatic logic known_addr(input logic [DAP_ADDR_W-1:0] a);
    known_addr = (a == OFF_PERIOD_0) || (a == OFF_PERIOD_1) || (a == OFF_ONTIME_0) ||
                 (a == OFF_ONTIME_1) || (a == OFF_MODE_CTRL) || (a == OFF_PORT_DATA_HIGH) ||
                 (a == OFF_PIN_FUNC_SEL) || (a == OFF_STATUS);
  endfunction

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge8 = s[0] ? d[7:0] : old;
  endfunction

  // Bus channels: address and data are captured in either order, then written.
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    do_write = 1'b0;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_held && w_held && !s_axi_bvalid) begin
      do_write = known_addr(aw_addr);
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = known_addr(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    next_awready = !next_aw_held && !next_bvalid;
    next_wready = !next_w_held && !next_bvalid;
  end

  // Register file; writes land regardless of timer state.
  always_comb begin
    next_period_0 = aux_period_0;
    next_period_1 = aux_period_1;
    next_ontime_0 = aux_ontime_0;
    next_ontime_1 = aux_ontime_1;
    next_mode = mode_control_register;
    next_pdh = port_data_high;
    next_pfs = pin_function_select;
    period_write = 1'b0;
    if (do_write) begin
      case (aw_addr)
        OFF_PERIOD_0: begin
          next_period_0 = merge8(aux_period_0, w_data, w_strb);
          period_write = 1'b1;
        end
        OFF_PERIOD_1: begin
          next_period_1 = merge8(aux_period_1, w_data, w_strb);
          period_write = 1'b1;
        end
        OFF_ONTIME_0: next_ontime_0 = merge8(aux_ontime_0, w_data, w_strb);
        OFF_ONTIME_1: next_ontime_1 = merge8(aux_ontime_1, w_data, w_strb);
        OFF_MODE_CTRL: begin
          if (w_strb[0]) next_mode[7:0] = w_data[7:0];
          if (w_strb[1]) next_mode[8] = w_data[8];
        end
        OFF_PORT_DATA_HIGH: if (w_strb[0]) next_pdh = w_data[1:0];
        OFF_PIN_FUNC_SEL: next_pfs = merge8(pin_function_select, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // Read channel: one read at a time, data registered with the valid.
  always_comb begin
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = known_addr(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFF_PERIOD_0: next_rdata = {24'h00_0000, aux_period_0};
        OFF_PERIOD_1: next_rdata = {24'h00_0000, aux_period_1};
        OFF_ONTIME_0: next_rdata = {24'h00_0000, aux_ontime_0};
        OFF_ONTIME_1: next_rdata = {24'h00_0000, aux_ontime_1};
        OFF_MODE_CTRL: next_rdata = {23'h00_0000, mode_control_register};
        OFF_PORT_DATA_HIGH: next_rdata = {30'h0000_0000, port_data_high};
        OFF_PIN_FUNC_SEL: next_rdata = {24'h00_0000, pin_function_select};
        OFF_STATUS: next_rdata = {30'h0000_0000, aux_out_one, aux_out_zero};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_period_0 <= RST_PERIOD;
      aux_period_1 <= RST_PERIOD;
      aux_ontime_0 <= RST_ONTIME;
      aux_ontime_1 <= RST_ONTIME;
      mode_control_register <= RST_MODE;
      port_data_high <= RST_PDH;
      pin_function_select <= RST_PFS;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      aux_period_0 <= next_period_0;
      aux_period_1 <= next_period_1;
      aux_ontime_0 <= next_ontime_0;
      aux_ontime_1 <= next_ontime_1;
      mode_control_register <= next_mode;
      port_data_high <= next_pdh;
      pin_function_select <= next_pfs;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= (s_axi_arready || s_axi_rvalid) ? next_arready : 1'b1;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  assign independent = mode_control_register[MODE_INDEP_BIT];
  assign per_1_eff = independent ? aux_period_1 : aux_period_0;
  assign step = phase;
  assign hold_1 = !independent && first_wait;
  assign restart_1 = period_write ||
                     (!independent && delay_run && step && delay_cnt >= aux_period_1);

  // Offset mode delay: output 1 restarts when the delay after output 0's cycle start expires.
  always_comb begin
    next_phase = period_write ? 1'b0 : !phase;
    next_delay_cnt = delay_cnt;
    next_delay_run = delay_run;
    // Output 1 is held until the offset delay first expires after reset or a period write, so only a period write cuts a long pulse.
    next_first_wait = period_write ? !independent : (first_wait && !restart_1);
    if (period_write || wrap_0) begin
      next_delay_cnt = 8'h00;
      next_delay_run = !independent;
    end else if (delay_run && step) begin
      if (delay_cnt >= aux_period_1) begin
        next_delay_run = 1'b0;
      end else begin
        next_delay_cnt = delay_cnt + 8'h01;
      end
    end
    next_out_zero = !port_data_high[PDH_FUNC_BIT] && wave_0;
    next_out_one = !pin_function_select[PFS_AUX_OUT_ONE_BIT] && wave_1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 1'b0;
      delay_cnt <= 8'h00;
      delay_run <= 1'b1;
      first_wait <= 1'b1;
      aux_out_zero <= 1'b0;
      aux_out_one <= 1'b0;
      aux_zero_is_aux <= 1'b0;
      aux_one_is_aux <= 1'b0;
    end else begin
      phase <= next_phase;
      delay_cnt <= next_delay_cnt;
      delay_run <= next_delay_run;
      first_wait <= next_first_wait;
      aux_out_zero <= next_out_zero;
      aux_out_one <= next_out_one;
      aux_zero_is_aux <= !port_data_high[PDH_FUNC_BIT];
      aux_one_is_aux <= !pin_function_select[PFS_AUX_OUT_ONE_BIT];
    end
  end

  dap_channel u_ch0 (
    .aclk(aclk), .aresetn(aresetn), .step(step), .restart(period_write), .hold(1'b0),
    .period(aux_period_0), .ontime(aux_ontime_0), .wave(wave_0), .wrap(wrap_0)
  );
  dap_channel u_ch1 (
    .aclk(aclk), .aresetn(aresetn), .step(step),
    .restart(restart_1), .hold(hold_1), .period(per_1_eff), .ontime(aux_ontime_1),
    .wave(wave_1), .wrap()
  );

  chk_reset_mode: assert property (@(posedge aclk) $rose(aresetn) |->
    mode_control_register == RST_MODE && aux_period_0 == RST_PERIOD)
    else $error("reset values wrong");
  chk_phase_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
    aresetn && !period_write |=> phase != $past(phase)) else $error("step not every two clocks");
  chk_zero_duty: assert property (@(posedge aclk) disable iff (!aresetn)
    (aux_ontime_0 == 8'h00 && u_ch0.on_live == 8'h00) |-> ##2 !aux_out_zero)
    else $error("zero on-time drove high");
  chk_pin0_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    port_data_high[PDH_FUNC_BIT] |=> !aux_out_zero) else $error("pin 0 not gated");
  chk_pin1_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_function_select[PFS_AUX_OUT_ONE_BIT] |=> !aux_out_one) else $error("pin 1 not gated");
  chk_period_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    period_write |=> !phase && u_ch0.count == 8'h00) else $error("period write no restart");
  chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    (aw_held && w_held && !s_axi_bvalid) |=> s_axi_bvalid) else $error("write not answered");
  chk_mode_select: assert property (@(posedge aclk) disable iff (!aresetn)
    (!independent && step && !hold_1 && !restart_1 && u_ch1.count < aux_period_0)
    |=> u_ch1.count == $past(u_ch1.count) + 8'h01) else $error("offset period wrong");
  cov_indep: cover property (@(posedge aclk) independent && aux_out_one);
  cov_offset: cover property (@(posedge aclk) !independent && $rose(aux_out_one));
  cov_period_write: cover property (@(posedge aclk) period_write);
endmodule

// *** verification/dap_load.sv ***
/*
  Passive model of the filter or converter input on the two auxiliary pins.
  Assumes the pins are sampled on the core clock; it measures rise-to-rise periods
  and the delay from an output 0 rise to the next output 1 rise.
*/
`timescale 1ns/1ns
module dap_load (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aux_out_zero,
  input wire logic aux_out_one,
  output logic [15:0] per0,
  output logic [15:0] per1,
  output logic [15:0] off
);
  logic [15:0] cyc;
  logic [15:0] rise0;
  logic [15:0] rise1;
  logic prev0;
  logic prev1;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc <= 16'h0000;
      rise0 <= 16'h0000;
      rise1 <= 16'h0000;
      prev0 <= 1'b0;
      prev1 <= 1'b0;
      per0 <= 16'h0000;
      per1 <= 16'h0000;
      off <= 16'h0000;
    end else begin
      cyc <= cyc + 16'h0001;
      prev0 <= aux_out_zero;
      prev1 <= aux_out_one;
      if (aux_out_zero && !prev0) begin
        rise0 <= cyc;
        per0 <= cyc - rise0;
      end
      if (aux_out_one && !prev1) begin
        rise1 <= cyc;
        per1 <= cyc - rise1;
        off <= cyc - rise0;
      end
    end
  end
endmodule

// *** verification/dap_timer_bench.sv ***
/*
  Self-checking bench for the dual auxiliary pulse-width timer.
  Assumes a 125 MHz clock and an AXI4-Lite master built from tasks in this file.
*/
`timescale 1ns/1ns
module dap_timer_bench;
  import dap_pkg::*;
  logic aclk;
  logic aresetn;
  logic [5:0] awaddr;
  logic [5:0] araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic out0, out1, is0, is1;
  logic [15:0] per0, per1, off;
  int error_cnt;
  int samples_checked;
  int h0, h1, t;
  logic [31:0] rst_tab [8] = '{32'h0000_00FF, 32'h0000_00FF, 32'h0000_0000, 32'h0000_0000,
                               32'h0000_0000, 32'h0000_0002, 32'h0000_00FF, 32'h0000_0000};

  dap_timer DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .aux_out_zero(out0), .aux_out_one(out1),
    .aux_zero_is_aux(is0), .aux_one_is_aux(is1));

  dap_load load (.aclk(aclk), .aresetn(aresetn), .aux_out_zero(out0),
    .aux_out_one(out1), .per0(per0), .per1(per1), .off(off));

  task automatic end_sim();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        chk(32'(bresp), 32'(er), "bresp");
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        chk(rdata, ed, "rdata");
        chk(32'(rresp), 32'(er), "rresp");
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  // Counts high clocks of both outputs over n cycles.
  task automatic meas(input int n);
    h0 = 0;
    h1 = 0;
    repeat (n) begin
      @(posedge aclk);
      h0 += int'(out0 === 1'b1);
      h1 += int'(out1 === 1'b1);
    end
  endtask

  task automatic wait_hi(input int lim);
    t = 0;
    while (out0 !== 1'b1 && t < lim) begin
      @(posedge aclk);
      t++;
    end
  endtask

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    end_sim();
  end

  initial begin
    error_cnt = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    awaddr = '0;
    awvalid = 1'b0;
    wdata = '0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = '0;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    for (int i = 0; i < 8; i++) rd(6'(i * 4), rst_tab[i], RESP_OKAY);
    rd(6'h20, 32'h0000_0000, RESP_SLVERR);
    wr(6'h24, 32'h0000_0001, RESP_SLVERR);
    chk(32'({is0, is1, out0, out1}), 32'h0000_0000, "pins idle");
    wr(OFF_PORT_DATA_HIGH, 32'h0000_0000, RESP_OKAY);
    wr(OFF_PIN_FUNC_SEL, 32'h0000_007F, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(32'({is0, is1}), 32'h0000_0003, "pins aux");
    wr(OFF_MODE_CTRL, 32'h0000_0100, RESP_OKAY);
    wr(OFF_ONTIME_0, 32'h0000_0002, RESP_OKAY);
    wr(OFF_ONTIME_1, 32'h0000_0003, RESP_OKAY);
    wr(OFF_PERIOD_1, 32'h0000_0005, RESP_OKAY);
    wr(OFF_PERIOD_0, 32'h0000_0003, RESP_OKAY);
    repeat (60) @(posedge aclk);
    meas(96);
    chk(32'(per0), 32'h0000_0008, "period 0");
    chk(32'(per1), 32'h0000_000C, "period 1");
    chk(32'(h0), 32'h0000_0030, "high 0");
    chk(32'(h1), 32'h0000_0030, "high 1");
    wr(OFF_ONTIME_0, 32'h0000_0000, RESP_OKAY);
    wr(OFF_ONTIME_1, 32'h0000_0006, RESP_OKAY);
    repeat (30) @(posedge aclk);
    meas(96);
    chk(32'(h0), 32'h0000_0000, "zero duty");
    chk(32'(h1), 32'h0000_0060, "full duty");
    wr(OFF_MODE_CTRL, 32'h0000_0000, RESP_OKAY);
    wr(OFF_ONTIME_0, 32'h0000_0004, RESP_OKAY);
    wr(OFF_ONTIME_1, 32'h0000_0003, RESP_OKAY);
    wr(OFF_PERIOD_1, 32'h0000_0002, RESP_OKAY);
    wr(OFF_PERIOD_0, 32'h0000_0007, RESP_OKAY);
    repeat (60) @(posedge aclk);
    meas(96);
    chk(32'(per0), 32'h0000_0010, "offset period 0");
    chk(32'(per1), 32'h0000_0010, "offset period 1");
    chk(32'(off), 32'h0000_0006, "offset delay");
    chk(32'(h0), 32'h0000_0030, "offset high 0");
    chk(32'(h1), 32'h0000_0024, "offset high 1");
    wr(OFF_ONTIME_0, 32'h0000_0001, RESP_OKAY);
    wr(OFF_PERIOD_0, 32'h0000_00FF, RESP_OKAY);
    repeat (100) @(posedge aclk);
    wr(OFF_PERIOD_0, 32'h0000_00FF, RESP_OKAY);
    wait_hi(8);
    chk(32'(t < 8), 32'h0000_0001, "restart on period write");
    repeat (100) @(posedge aclk);
    wr(OFF_ONTIME_0, 32'h0000_00C8, RESP_OKAY);
    meas(300);
    chk(32'(h0), 32'h0000_0000, "on-time held mid-cycle");
    wait_hi(250);
    chk(32'(t < 250), 32'h0000_0001, "on-time at next cycle");
    wr(OFF_PORT_DATA_HIGH, 32'h0000_0002, RESP_OKAY);
    wr(OFF_PIN_FUNC_SEL, 32'h0000_00FF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    meas(40);
    chk(32'({is0, is1, 30'(h0 + h1)}), 32'h0000_0000, "pins back to port");
    end_sim();
  end
endmodule
